// *** hw/fault_pkg.sv ***
// constants, register map and carrier types for the battery fault logic
// assumes a single 20 MHz reference clock and a word-wide bus slave
package fault_pkg;
   localparam int CLK_HZ         = 20_000_000;
   localparam int DEB_TIME_US    = 100;
   localparam int DEB_CYC        = DEB_TIME_US * (CLK_HZ / 1_000_000);
   localparam int TICK_TIME_US   = 100;
   localparam int TICK_CYC       = TICK_TIME_US * (CLK_HZ / 1_000_000);
   localparam int OW_ON_TIME_US  = 10;
   localparam int OW_ON_CYC      = OW_ON_TIME_US * (CLK_HZ / 1_000_000);

   // byte addresses
   localparam logic [7:0] A_PROT_EN  = 8'h00;
   localparam logic [7:0] A_AUTO_SEL = 8'h04;
   localparam logic [7:0] A_POLICY   = 8'h08;
   localparam logic [7:0] A_REC_DLY  = 8'h0C;
   localparam logic [7:0] A_RETRY    = 8'h10;
   localparam logic [7:0] A_OW_INT   = 8'h14;
   localparam logic [7:0] A_OFFSET0  = 8'h20;
   localparam logic [7:0] A_GAIN0    = 8'h30;
   localparam logic [7:0] A_RESULT0  = 8'h40;
   localparam logic [7:0] A_STATUS   = 8'h80;
   localparam logic [7:0] A_OW_STAT  = 8'h84;
   localparam logic [7:0] A_INFO     = 8'h88;

   // policy field encodings
   localparam logic [1:0] POL_AUTO    = 2'h0;
   localparam logic [1:0] POL_HOSTREC = 2'h1;
   localparam logic [1:0] POL_MONITOR = 2'h2;
   // policy register bit positions
   localparam int P_CHG_ON_CUR = 2;
   localparam int P_ALERT_EN   = 3;
   localparam int P_HWOT_EN    = 4;
   // info register bit positions
   localparam int I_ALERT_CLR  = 8;
   localparam int I_RETRY_CLR  = 9;

   // fault flag positions
   localparam int F_OCC  = 2;
   localparam int F_SCD  = 5;
   localparam int F_OW   = 12;
   localparam int F_VREF = 13;
   localparam int F_VSS  = 14;
   localparam int F_REG  = 15;
   localparam logic [15:0] CUR_MASK  = 16'h003C;
   localparam logic [15:0] DIAG_MASK = 16'hF000;

   // reset values
   localparam logic [15:0] GAIN_ONE   = 16'h4000;
   localparam logic [15:0] PROT_RST   = 16'hFFFF;
   localparam logic [15:0] AUTO_RST   = 16'hFFFF;
   localparam logic [15:0] REC_RST    = 16'h2710;
   localparam logic [3:0]  RETRY_RST  = 4'h3;
   localparam logic [15:0] OW_INT_RST = 16'h0000;

   // diagnostic windows on raw converter counts
   localparam logic [15:0] LDO_LO    = 16'h6C00;
   localparam logic [15:0] LDO_HI    = 16'h7400;
   localparam logic [15:0] VSS_MAX   = 16'h0040;
   localparam logic [15:0] OW_LIMIT  = 16'h01F4;

   localparam int NCELL = 7;
   localparam int NCHAN = 12;
   localparam logic [3:0] CH_LDO = 4'hA;
   localparam logic [3:0] CH_VSS = 4'hB;

   typedef enum logic [1:0] {ST_CHECK, ST_RUN, ST_SHUT} state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       act;
   } busPhase_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] chan;
      logic [15:0] data;
   } rawSample_t;
endpackage : fault_pkg

// *** hw/battery_fault_logic.sv ***
// fault handling, trim correction and diagnostics behind an AHB-Lite slave
// assumes converter samples and evaluated conditions come from logic on
// ref_clk; comparator, detector and oscillator-monitor levels are async pins
// Behaviour
// - trim-correct raw readings of channels 0-9, keep channels 10-11 raw, and publish a 16-bit result per channel
// - default current gain gives mA for one milliohm; software may rescale
// - offset and gain stay writable and apply to later corrections
// - per-protection enable plus a per-protection FET action select
// - policies: auto act+recover, auto act host recover, monitor only
// - current faults from comparators, others from converter or logic
// - raw charge-pin detector state readable by the host
// - alert on each debounced detector change when enabled
// - current fault drops discharge FET, charge FET per configuration
// - auto recovery waits programmed delay then re-enables FETs
// - retry counter blocks auto recovery once limit reached
// - periodic open-wire current on all cell inputs, interval programmable
// - sagging floating cell flags open wire on it and cell above
// - diagnostic faults set at once, no alert phase or delay
// - non-recovering diagnostic faults cleared by host command
// - LDO reading outside window raises reference-check fault
// - ground reading off expectation raises ground check fault
// - stack-top reading published for host comparison
// - regulator error raises diagnostic fault, optionally drops FETs
// - oscillator failure sends device to shutdown at once
// - trim check at reset release; error means shutdown
// - hardware overtemperature starts shutdown when enabled
// - entering shutdown loses all register settings
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module battery_fault_logic (
   input  wire logic                  ref_clk,          // 20 MHz clock
   input  wire logic                  rstn,             // sync reset
   input  wire logic                  hsel,             // slave select
   input  wire logic [31:0]           haddr,            // byte address
   input  wire logic [1:0]            htrans,           // transfer type
   input  wire logic                  hwrite,           // write
   input  wire logic [2:0]            hsize,            // transfer size
   input  wire logic [31:0]           hwdata,           // write data
   input  wire logic                  hready,           // bus ready
   output logic                       hreadyout,        // slave ready
   output logic [31:0]                hrdata,           // read data
   output logic                       hresp,            // always okay
   input  wire fault_pkg::rawSample_t raw,              // converter sample
   input  wire logic [7:0]            evalCond,         // evaluated faults
   input  wire logic [3:0]            cmpOut,           // current comps
   input  wire logic                  regErrPin,        // regulator error
   input  wire logic                  oscFailPin,       // osc monitor
   input  wire logic                  hwOtPin,          // die overtemp
   input  wire logic                  chgDetPin,        // charge-pin det
   input  wire logic                  trimErr,          // trim check error
   output logic                       charge_fet_drive, // charge FET on
   output logic                       discharge_fet_drive, // dsg FET on
   output logic [6:0]                 openWireSink,     // cell sinks on
   output logic                       alert,            // alert, high
   output logic                       shutdownReq       // enter shutdown
);
   import fault_pkg::*;

   // async levels through two flops: cmp[3:0], reg, osc, hwot, chgdet
   logic [7:0]  syncA_q, syncB_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         syncA_q <= 8'h00;
         syncB_q <= 8'h00;
      end else begin
         syncA_q <= {cmpOut, regErrPin, oscFailPin, hwOtPin, chgDetPin};
         syncB_q <= syncA_q;
      end
   end
   logic cmpScd, regErr, oscFail, hwOt, chgDet;
   assign regErr  = syncB_q[3];
   assign oscFail = syncB_q[2];
   assign hwOt    = syncB_q[1];
   assign chgDet  = syncB_q[0];

   function automatic logic [15:0] applyTrim(input logic [15:0] r,
         input logic [15:0] off, input logic [15:0] gain);
      logic signed [31:0] p;
      p = $signed(r) * $signed(gain);
      return p[29:14] + off;
   endfunction : applyTrim

   function automatic logic [1:0] trimGroup(input logic [3:0] ch);
      if (ch < 4'h7)       return 2'd0;
      else if (ch == 4'h7) return 2'd1;
      else if (ch == 4'h8) return 2'd2;
      else                 return 2'd3;
   endfunction : trimGroup

   // ---------------- state ----------------
   state_t stateQ;
   logic   goShut;
   always_ff @(posedge ref_clk) begin
      if (!rstn) stateQ <= ST_CHECK;
      else begin
         case (stateQ)
            ST_CHECK: stateQ <= trimErr ? ST_SHUT : ST_RUN;
            ST_RUN:   if (goShut) stateQ <= ST_SHUT;
            ST_SHUT:  stateQ <= ST_SHUT;
            default:  stateQ <= ST_SHUT;
         endcase
      end
   end
   logic clrCfg;
   // shutdown wipes configuration and holds it at reset values
   assign clrCfg = !rstn || stateQ == ST_SHUT;

   // ---------------- bus slave ----------------
   busPhase_t phaseQ;
   logic      wrEn;
   always_ff @(posedge ref_clk) begin
      if (!rstn) phaseQ <= '0;
      else if (hready) begin
         phaseQ.act  <= hsel && htrans[1];
         phaseQ.wr   <= hwrite;
         phaseQ.addr <= haddr[7:0];
      end
   end
   assign wrEn      = phaseQ.act && phaseQ.wr && stateQ != ST_SHUT;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function automatic logic wrHit(input busPhase_t ph, input logic we,
         input logic [7:0] a);
      return we && ph.addr == a;
   endfunction : wrHit

   logic [15:0] protEnQ, autoQ, recDlyQ, owIntQ;
   logic [4:0]  policyQ;
   logic [3:0]  retryLimQ;
   logic [15:0] offQ [4];
   logic [15:0] gainQ [4];
   always_ff @(posedge ref_clk) begin
      if (clrCfg) begin
         protEnQ   <= PROT_RST;
         autoQ     <= AUTO_RST;
         policyQ   <= 5'h00;
         recDlyQ   <= REC_RST;
         retryLimQ <= RETRY_RST;
         owIntQ    <= OW_INT_RST;
      end else begin
         if (wrHit(phaseQ, wrEn, A_PROT_EN))  protEnQ <= hwdata[15:0];
         if (wrHit(phaseQ, wrEn, A_AUTO_SEL)) autoQ   <= hwdata[15:0];
         if (wrHit(phaseQ, wrEn, A_POLICY))   policyQ <= hwdata[4:0];
         if (wrHit(phaseQ, wrEn, A_REC_DLY))  recDlyQ <= hwdata[15:0];
         if (wrHit(phaseQ, wrEn, A_RETRY))    retryLimQ <= hwdata[3:0];
         if (wrHit(phaseQ, wrEn, A_OW_INT))   owIntQ  <= hwdata[15:0];
      end
   end

   // trim: gain 0x4000 is unity, so current stays in mA for one milliohm
   always_ff @(posedge ref_clk) begin
      for (int g = 0; g < 4; g++) begin
         if (clrCfg) begin
            offQ[g]  <= 16'h0000;
            gainQ[g] <= GAIN_ONE;
         end else begin
            if (wrHit(phaseQ, wrEn, A_OFFSET0 + 8'(4 * g)))
               offQ[g] <= hwdata[15:0];
            if (wrHit(phaseQ, wrEn, A_GAIN0 + 8'(4 * g)))
               gainQ[g] <= hwdata[15:0];
         end
      end
   end

   // ---------------- processed results ----------------
   logic [15:0] resultQ [NCHAN];
   logic [1:0]  grp;
   assign grp = trimGroup(raw.chan);
   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < NCHAN; c++) begin
         if (!rstn) resultQ[c] <= 16'h0000;
         else if (raw.valid && raw.chan == 4'(c)) begin
            // stack top lands in its own slot for the host sum check
            if (c < 10)
               resultQ[c] <= applyTrim(raw.data, offQ[grp], gainQ[grp]);
            else
               resultQ[c] <= raw.data;
         end
      end
   end

   // diagnostics from converter samples, one-cycle events
   logic vrefBadQ, vssBadQ;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         vrefBadQ <= 1'b0;
         vssBadQ  <= 1'b0;
      end else begin
         vrefBadQ <= raw.valid && raw.chan == CH_LDO &&
                     (raw.data < LDO_LO || raw.data > LDO_HI);
         vssBadQ  <= raw.valid && raw.chan == CH_VSS &&
                     raw.data > VSS_MAX;
      end
   end

   // ---------------- open wire ----------------
   logic [12:0] tickCntQ;
   logic        tick;
   logic [15:0] owCntQ;
   logic [8:0]  owOnQ;
   logic [6:0]  owFlagQ;
   assign tick = tickCntQ == 13'(TICK_CYC - 1);
   always_ff @(posedge ref_clk) begin
      if (!rstn || tick) tickCntQ <= 13'h0000;
      else               tickCntQ <= tickCntQ + 13'h0001;
   end
   // a zero interval leaves the sinks off; each pulse costs cell charge
   always_ff @(posedge ref_clk) begin
      if (clrCfg || owIntQ == 16'h0000) begin
         owCntQ <= 16'h0000;
         owOnQ  <= 9'h000;
      end else begin
         if (tick) begin
            if (owCntQ >= owIntQ - 16'h0001) begin
               owCntQ <= 16'h0000;
               owOnQ  <= 9'(OW_ON_CYC);
            end else owCntQ <= owCntQ + 16'h0001;
         end
         if (owOnQ != 9'h000 && !(tick && owCntQ >= owIntQ - 16'h0001))
            owOnQ <= owOnQ - 9'h001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) openWireSink <= 7'h00;
      else       openWireSink <= (owOnQ != 9'h000) ? 7'h7F : 7'h00;
   end
   logic [6:0] owSet, owClr;
   always_comb begin
      owSet = 7'h00;
      if (raw.valid && raw.chan < 4'(NCELL) && raw.data < OW_LIMIT) begin
         owSet[raw.chan[2:0]] = 1'b1;
         if (raw.chan < 4'(NCELL - 1))
            owSet[raw.chan[2:0] + 3'd1] = 1'b1;
      end
      owClr = wrHit(phaseQ, wrEn, A_OW_STAT) ? hwdata[6:0] : 7'h00;
   end
   always_ff @(posedge ref_clk) begin
      if (clrCfg) owFlagQ <= 7'h00;
      else        owFlagQ <= (owFlagQ & ~owClr) | owSet;
   end

   // ---------------- protection flags ----------------
   logic [15:0] condVec, flagQ, setVec, clrVec;
   logic        recExpire, latched, hostRec;
   assign cmpScd  = syncB_q[7];
   // current tiers from comparators, top four from regulator, converter and open wire, the rest from evaluation
   assign condVec = {regErr, vssBadQ, vrefBadQ, |owFlagQ, evalCond[7:2],
                     cmpScd, syncB_q[6:4], evalCond[1:0]};
   assign setVec  = condVec & protEnQ;
   assign hostRec = wrHit(phaseQ, wrEn, A_STATUS);
   always_comb begin
      clrVec = hostRec ? hwdata[15:0] : 16'h0000;
      if (policyQ[1:0] == POL_AUTO) begin
         clrVec = clrVec | (~condVec & ~CUR_MASK & ~DIAG_MASK);
         if (recExpire) clrVec = clrVec | CUR_MASK;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (clrCfg) flagQ <= 16'h0000;
      else        flagQ <= (flagQ & ~clrVec) | setVec;
   end

   // ---------------- recovery timer and latch ----------------
   logic [15:0] recCntQ;
   logic [3:0]  retryCntQ;
   logic        curFault;
   assign curFault  = |(flagQ & CUR_MASK);
   assign latched   = retryLimQ != 4'h0 && retryCntQ >= retryLimQ;
   assign recExpire = curFault && !latched && policyQ[1:0] == POL_AUTO &&
                      tick && recCntQ >= recDlyQ;
   always_ff @(posedge ref_clk) begin
      if (clrCfg || !curFault || recExpire) recCntQ <= 16'h0000;
      else if (tick && recCntQ != 16'hFFFF) recCntQ <= recCntQ + 16'h0001;
   end
   always_ff @(posedge ref_clk) begin
      if (clrCfg) retryCntQ <= 4'h0;
      else if (wrHit(phaseQ, wrEn, A_INFO) && hwdata[I_RETRY_CLR])
         retryCntQ <= 4'h0;
      else if (recExpire && retryCntQ != 4'hF)
         retryCntQ <= retryCntQ + 4'h1;
   end

   // ---------------- FET drive ----------------
   logic fetAct, dsgOff, chgOff;
   logic [15:0] actFlags;
   assign fetAct   = policyQ[1:0] != POL_MONITOR;
   assign actFlags = flagQ & autoQ;
   assign dsgOff   = fetAct && |actFlags;
   assign chgOff   = fetAct && (|(actFlags & ~CUR_MASK) ||
                     (policyQ[P_CHG_ON_CUR] && |(actFlags & CUR_MASK)));
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         charge_fet_drive    <= 1'b0;
         discharge_fet_drive <= 1'b0;
      end else begin
         discharge_fet_drive <= stateQ == ST_RUN && !dsgOff;
         charge_fet_drive    <= stateQ == ST_RUN && !chgOff;
      end
   end

   assign goShut = oscFail || (hwOt && policyQ[P_HWOT_EN]);
   assign shutdownReq = stateQ == ST_SHUT;

   // ---------------- charge-pin detector and alert ----------------
   logic [10:0] debCntQ;
   logic        chgDbQ, dbEdge, alertFlagQ, alertClr;
   assign dbEdge = chgDet != chgDbQ && debCntQ == 11'(DEB_CYC - 1);
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         debCntQ <= 11'h000;
         chgDbQ  <= 1'b0;
      end else if (chgDet == chgDbQ) debCntQ <= 11'h000;
      else if (dbEdge) begin
         debCntQ <= 11'h000;
         chgDbQ  <= chgDet;
      end else debCntQ <= debCntQ + 11'h001;
   end
   assign alertClr = wrHit(phaseQ, wrEn, A_INFO) && hwdata[I_ALERT_CLR];
   always_ff @(posedge ref_clk) begin
      if (clrCfg) alertFlagQ <= 1'b0;
      else if (dbEdge && policyQ[P_ALERT_EN]) alertFlagQ <= 1'b1;
      else if (alertClr) alertFlagQ <= 1'b0;
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) alert <= 1'b0;
      else alert <= alertFlagQ ||
                    (policyQ[1:0] == POL_MONITOR && |flagQ);
   end

   // ---------------- read mux ----------------
   logic [31:0] rdD;
   logic [7:0]  ra;
   always_comb begin
      ra  = haddr[7:0];
      rdD = 32'h0000_0000;
      case (ra)
         A_PROT_EN:  rdD[15:0] = protEnQ;
         A_AUTO_SEL: rdD[15:0] = autoQ;
         A_POLICY:   rdD[4:0]  = policyQ;
         A_REC_DLY:  rdD[15:0] = recDlyQ;
         A_RETRY:    rdD[3:0]  = retryLimQ;
         A_OW_INT:   rdD[15:0] = owIntQ;
         A_STATUS:   rdD[15:0] = flagQ;
         A_OW_STAT:  rdD[6:0]  = owFlagQ;
         A_INFO:     rdD[11:0] = {retryCntQ, alertFlagQ, 2'b00,
                                  charge_fet_drive, discharge_fet_drive,
                                  latched, chgDbQ, chgDet};
         default: begin
            for (int g = 0; g < 4; g++) begin
               if (ra == A_OFFSET0 + 8'(4 * g)) rdD[15:0] = offQ[g];
               if (ra == A_GAIN0 + 8'(4 * g))   rdD[15:0] = gainQ[g];
            end
            for (int c = 0; c < NCHAN; c++)
               if (ra == A_RESULT0 + 8'(4 * c)) rdD[15:0] = resultQ[c];
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite) hrdata <= rdD;
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_trim;
      raw.valid && raw.chan == 4'h7 |=> resultQ[7] ==
         applyTrim($past(raw.data), $past(offQ[1]), $past(gainQ[1]));
   endproperty
   a_trim: assert property (p_trim) else $error("stack trim wrong");

   property p_offWrite;
      wrEn && phaseQ.addr == A_OFFSET0 |=> offQ[0] == $past(hwdata[15:0]);
   endproperty
   a_offWrite: assert property (p_offWrite)
      else $error("offset write lost");

   property p_scdDsg;
      stateQ == ST_RUN && fetAct && flagQ[F_SCD] && autoQ[F_SCD]
         |=> !discharge_fet_drive;
   endproperty
   a_scdDsg: assert property (p_scdDsg)
      else $error("dsg on during short");

   property p_alertEdge;
      dbEdge && policyQ[P_ALERT_EN] |=> alertFlagQ ##1 alert;
   endproperty
   a_alertEdge: assert property (p_alertEdge)
      else $error("detector change not alerted");

   // once latched, only the host may clear a current fault
   property p_latchBlocks;
      latched && curFault && !hostRec && !clrCfg |=> curFault;
   endproperty
   a_latchBlocks: assert property (p_latchBlocks)
      else $error("recovery past retry limit");

   property p_diagNow;
      setVec[F_VREF] |=> flagQ[F_VREF];
   endproperty
   a_diagNow: assert property (p_diagNow)
      else $error("diag fault delayed");

   property p_diagHold;
      flagQ[F_VSS] && !(hostRec && hwdata[F_VSS]) && !clrCfg
         |=> flagQ[F_VSS];
   endproperty
   a_diagHold: assert property (p_diagHold)
      else $error("diag fault cleared itself");

   property p_oscShut;
      stateQ == ST_RUN && oscFail |=> shutdownReq ##1 !discharge_fet_drive;
   endproperty
   a_oscShut: assert property (p_oscShut)
      else $error("no shutdown on osc fail");

   property p_trimChk;
      stateQ == ST_CHECK && trimErr |=> stateQ == ST_SHUT;
   endproperty
   a_trimChk: assert property (p_trimChk)
      else $error("trim error not shut down");

   property p_shutWipe;
      shutdownReq |=> protEnQ == PROT_RST && policyQ == 5'h00;
   endproperty
   a_shutWipe: assert property (p_shutWipe)
      else $error("settings survive shutdown");

   c_recover: cover property (recExpire ##1 !curFault);
   c_latch:   cover property (!latched ##1 latched);
   c_owPulse: cover property ($rose(openWireSink[0]));
   c_alert:   cover property ($rose(alert));
endmodule : battery_fault_logic

// *** bench/host_model.sv ***
// host side bus master model: single word transfers on AHB-Lite
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ps
module host_model (
   input  wire logic        ref_clk, // bus clock
   input  wire logic        hready,  // slave ready
   input  wire logic [31:0] hrdata,  // read data
   output logic             hsel,    // select
   output logic [31:0]      haddr,   // byte address
   output logic [1:0]       htrans,  // transfer type
   output logic             hwrite,  // write
   output logic [2:0]       hsize,   // always a word
   output logic [31:0]      hwdata,  // write data
   output logic             hang     // slave never answered
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, hang} = '0;
      hsize = 3'h2;
   end

   // bounded so a dead slave ends the run instead of hanging it
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) hang <= 1'b1;
   endtask : wait_ready

   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
endmodule : host_model

// *** bench/battery_fault_logic_tb.sv ***
// self-checking bench for the battery fault logic
// assumes the host model as bus master and a 20 MHz reference clock
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   failures++; $display("ERROR %s expected %h seen %h", n, e, s); end end
module battery_fault_logic_tb;
   import fault_pkg::*;
   logic        ref_clk, rstn, hsel, hwrite, hreadyout, hresp, hang;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   rawSample_t  raw;
   logic [3:0]  cmpOut;
   logic        oscFailPin, chgDetPin, chgFet, dsgFet, alert, shutdownReq;
   logic        regErrPin, hwOtPin, trimErr;
   logic [7:0]  evalCond;
   logic [6:0]  openWireSink;
   int          failures, comparisons, i;

   battery_fault_logic u_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .raw(raw), .evalCond(evalCond),
      .cmpOut(cmpOut), .regErrPin(regErrPin), .oscFailPin(oscFailPin),
      .hwOtPin(hwOtPin), .chgDetPin(chgDetPin), .trimErr(trimErr),
      .charge_fet_drive(chgFet), .discharge_fet_drive(dsgFet),
      .openWireSink(openWireSink), .alert(alert),
      .shutdownReq(shutdownReq));
   host_model u_host (.ref_clk(ref_clk), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic give_up();
      failures++;
      give_verdict();
   endtask : give_up

   always @(posedge hang) give_up();

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, rd);
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0000_0000, rd);
   endtask : rd_reg

   task automatic send_raw(input logic [3:0] ch, input logic [15:0] d);
      @(posedge ref_clk);
      raw <= '{1'b1, ch, d};
      @(posedge ref_clk);
      raw.valid <= 1'b0;
   endtask : send_raw

   task automatic check_reset();
      cyc(5);
      `CHK("dsg on", 1'b1, dsgFet)
      rd_reg(A_PROT_EN);
      `CHK("prot_en", 32'h0000_FFFF, rd)
      rd_reg(A_REC_DLY);
      `CHK("rec_dly", 32'h0000_2710, rd)
      rd_reg(8'h7C);
      `CHK("unmapped", 32'h0000_0000, rd)
   endtask : check_reset

   task automatic trim();
      wr(A_GAIN0, 32'h0000_2000);
      wr(A_OFFSET0, 32'h0000_0005);
      send_raw(4'h0, 16'h1000);
      rd_reg(A_RESULT0);
      `CHK("cell0", 32'h0000_0805, rd)
      send_raw(4'h9, 16'h00FA);
      rd_reg(A_RESULT0 + 8'h24);
      `CHK("current", 32'h0000_00FA, rd)
   endtask : trim

   task automatic cur_fault();
      cmpOut <= 4'h8;
      cyc(6);
      `CHK("dsg off", 1'b0, dsgFet)
      `CHK("chg kept", 1'b1, chgFet)
      rd_reg(A_STATUS);
      `CHK("short flag", 1'b1, rd[F_SCD])
      wr(A_REC_DLY, 32'h0000_0001);
      cmpOut <= 4'h0;
      for (i = 0; i < 6000 && dsgFet !== 1'b1; i++) cyc(1);
      if (i == 6000) give_up();
      rd_reg(A_INFO);
      `CHK("retries", 4'h1, rd[11:8])
      rd_reg(A_STATUS);
      `CHK("short clr", 1'b0, rd[F_SCD])
      // limit of one is already used up, so a new short must stay latched
      wr(A_RETRY, 32'h0000_0001);
      cmpOut <= 4'h8;
      cyc(4);
      cmpOut <= 4'h0;
      cyc(4100);
      rd_reg(A_INFO);
      `CHK("latched", 1'b1, rd[2])
      `CHK("latch dsg", 1'b0, dsgFet)
      wr(A_STATUS, 32'h0000_0020);
      rd_reg(A_STATUS);
      `CHK("host cur clr", 16'h0000, rd[15:0])
   endtask : cur_fault

   task automatic diag();
      send_raw(CH_LDO, 16'h0000);
      send_raw(CH_VSS, 16'h0041);
      cyc(2);
      `CHK("diag dsg", 1'b0, dsgFet)
      rd_reg(A_STATUS);
      `CHK("diag flags", 4'h6, rd[15:12])
      wr(A_STATUS, 32'h0000_FFFF);
      rd_reg(A_STATUS);
      `CHK("host clr", 16'h0000, rd[15:0])
   endtask : diag

   task automatic policy_modes();
      wr(A_POLICY, 32'h0000_0002);
      regErrPin <= 1'b1;
      cyc(5);
      `CHK("mon dsg", 1'b1, dsgFet)
      `CHK("mon alert", 1'b1, alert)
      regErrPin <= 1'b0;
      wr(A_POLICY, 32'h0000_0000);
      cyc(2);
      `CHK("reg dsg", 1'b0, dsgFet)
      wr(A_STATUS, 32'h0000_8000);
      evalCond <= 8'h01;
      cyc(3);
      `CHK("uv dsg", 1'b0, dsgFet)
      evalCond <= 8'h00;
      cyc(3);
      `CHK("uv recover", 1'b1, dsgFet)
   endtask : policy_modes

   task automatic detector();
      wr(A_POLICY, 32'h0000_0008);
      chgDetPin <= 1'b1;
      cyc(4);
      rd_reg(A_INFO);
      `CHK("raw det", 1'b1, rd[0])
      cyc(2100);
      `CHK("alert set", 1'b1, alert)
      wr(A_INFO, 32'h0000_0100);
      cyc(2);
      `CHK("alert clr", 1'b0, alert)
   endtask : detector

   task automatic open_wire();
      wr(A_OW_INT, 32'h0000_0001);
      for (i = 0; i < 4000 && openWireSink !== 7'h7F; i++) cyc(1);
      if (i == 4000) give_up();
      send_raw(4'h2, 16'h01F3);
      rd_reg(A_OW_STAT);
      `CHK("ow cells", 7'h0C, rd[6:0])
   endtask : open_wire

   task automatic shut();
      hwOtPin <= 1'b1;
      cyc(4);
      `CHK("ot ignored", 1'b0, shutdownReq)
      wr(A_POLICY, 32'h0000_0010);
      cyc(2);
      `CHK("ot shutdown", 1'b1, shutdownReq)
      wr(A_PROT_EN, 32'h0000_0000);
      rd_reg(A_PROT_EN);
      `CHK("lost cfg", 32'h0000_FFFF, rd)
      // shutdown is sticky, so each further cause needs its own reset
      hwOtPin <= 1'b0;
      rstn <= 1'b0;
      cyc(2);
      rstn <= 1'b1;
      oscFailPin <= 1'b1;
      cyc(4);
      `CHK("shutdown", 1'b1, shutdownReq)
      oscFailPin <= 1'b0;
      trimErr <= 1'b1;
      rstn <= 1'b0;
      cyc(2);
      rstn <= 1'b1;
      cyc(3);
      `CHK("trim shut", 1'b1, shutdownReq)
   endtask : shut

   initial begin
      {rstn, cmpOut, oscFailPin, chgDetPin, failures, comparisons} = '0;
      {regErrPin, hwOtPin, trimErr, evalCond} = '0;
      raw = '0;
      cyc(2);
      rstn <= 1'b1;
      check_reset();
      trim();
      cur_fault();
      diag();
      policy_modes();
      detector();
      open_wire();
      shut();
      give_verdict();
   end
endmodule : battery_fault_logic_tb
